// file: src/saf_fsm.sv
// Layer-1 activation state machine for exchange-side and NT roles
//
// Contract
// [R1] Command 0000 deactivates, sending INFO 0
// [R2] Command 0001 resets machine, ignores line
// [R3] Commands 0010/0011 select pulse test modes
// [R4] Controller never swaps pulse tests directly
// [R5] Command 1000 starts exchange activation
// [R6] Command 1010 activates with analog loopback
// [R7] Command 1110 closes loop 2 when active
// [R8] Command 1111 enters deactivated, detection enabled
// [R9] Indication 0000 reports interim timing
// [R10] Indication 0100 while receiver unsynchronized
// [R11] Indication 1000 when INFO 0 received; exchange-side role indicates 0000 instead
// [R12] Indication 1011 on violation when enabled
// [R13] Indication 1100 when synced and activated
// [R14] Indication 1111 after 16/32 ms timers
// [R15] Deactivated: silent, clock stop selectable
// [R16] NT waits activation command after detection
// [R17] Pending activation sends INFO 2, loop option
// [R18] NT keeps INFO 2 until switch-through
// [R19] Switch-through sends INFO 4, channels transparent
// [R20] Lost sync when activated goes lost-framing
// [R21] NT upstream-unsynced command sends INFO 2
// [R22] Wait for confirmation after deactivation indication
// [R23] Controller holds command until action starts
// [R24] Timers restart on pending-deactivation entry
`timescale 1ns/1ns
module saf_fsm
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Role and configuration
    input wire logic nt_mode,
    input wire logic code_violation_enable,
    input wire logic clock_stop_select,
    // Control channel
    input wire logic [3:0] cmd_code,
    output logic [3:0] ind_code,
    // Line receiver status, from the line clock side
    input wire saf_pkg::saf_rx_type rx_status,
    // Line transmitter and path control
    output saf_pkg::saf_tx_type tx_info,
    output logic channels_transparent,
    output logic loop_closed,
    output logic clocks_stopped
);
    // Two-stage synchronisers for line status
    saf_pkg::saf_rx_type rx_meta;
    saf_pkg::saf_rx_type rx;
    always_ff @(posedge clk)
    begin
        rx_meta <= rx_status;
        rx <= rx_meta;
    end

    saf_pkg::saf_state_type state;
    saf_pkg::saf_state_type next_state;
    logic [19:0] quiet_count;
    logic [19:0] expiry_count;
    logic next_loop;

    // Timer expiry decode
    wire quiet_done = quiet_count >= 20'(saf_pkg::QUIET_CYCLES - 1);
    wire expiry_done = expiry_count >= 20'(saf_pkg::EXPIRY_CYCLES - 1);
    wire deact_fire = quiet_done || expiry_done; // [R14]
    wire is_test = (state == saf_pkg::ST_TEST_SINGLE)
        || (state == saf_pkg::ST_TEST_CONT);
    wire act_cmd = (cmd_code == saf_pkg::CMD_ACT_REQ)
        || (cmd_code == saf_pkg::CMD_LOOP_ACT_REQ);

    // Next-state selection
    always_comb
    begin
        next_state = state;
        next_loop = loop_closed;
        case (state)
            saf_pkg::ST_RESET:
                if (cmd_code != saf_pkg::CMD_RESET)
                    next_state = saf_pkg::ST_DEACTIVATED;
            saf_pkg::ST_DEACTIVATED:
            begin
                next_loop = 1'b0;
                if (act_cmd)
                    next_state = saf_pkg::ST_PEND_ACT; // [R5]
                else if (rx.info0 && nt_mode)
                    next_state = saf_pkg::ST_INFO0_SEEN; // [R16]
                else if (rx.info0)
                    next_state = saf_pkg::ST_PEND_ACT;
            end
            saf_pkg::ST_INFO0_SEEN:
                if (act_cmd)
                    next_state = saf_pkg::ST_PEND_ACT; // [R16]
            saf_pkg::ST_PEND_ACT:
            begin
                next_loop = cmd_code == saf_pkg::CMD_LOOP_ACT_REQ; // [R6]
                if (rx.info3 && rx.synced)
                    next_state = nt_mode ? saf_pkg::ST_WAIT_SWITCH
                        : saf_pkg::ST_ACTIVATED; // [R17]
            end
            saf_pkg::ST_WAIT_SWITCH:
                if (cmd_code == saf_pkg::CMD_SWITCH_THROUGH
                    || cmd_code == saf_pkg::CMD_LOOP_ACT_IND)
                    next_state = saf_pkg::ST_ACTIVATED; // [R18]
            saf_pkg::ST_ACTIVATED:
            begin
                if (cmd_code == saf_pkg::CMD_LOOP_ACT_IND)
                    next_loop = 1'b1; // [R7]
                if (!rx.synced)
                    next_state = saf_pkg::ST_LOST_LINE; // [R20]
                else if (nt_mode && cmd_code == saf_pkg::CMD_RX_UNSYNCED)
                    next_state = saf_pkg::ST_LOST_UP; // [R21]
            end
            saf_pkg::ST_LOST_LINE:
                if (rx.synced && rx.info3)
                    next_state = saf_pkg::ST_ACTIVATED;
            saf_pkg::ST_LOST_UP:
                if (cmd_code != saf_pkg::CMD_RX_UNSYNCED)
                    next_state = saf_pkg::ST_ACTIVATED;
            saf_pkg::ST_PEND_DEACT:
                if (deact_fire)
                    next_state = saf_pkg::ST_WAIT_CONFIRM; // [R14]
            saf_pkg::ST_WAIT_CONFIRM:
                if (cmd_code == saf_pkg::CMD_DEACT_CONFIRM)
                    next_state = saf_pkg::ST_DEACTIVATED; // [R22] [R8]
            saf_pkg::ST_TEST_SINGLE,
            saf_pkg::ST_TEST_CONT:
                if (cmd_code != saf_pkg::CMD_SINGLE_PULSE
                    && cmd_code != saf_pkg::CMD_CONT_PULSE)
                    next_state = saf_pkg::ST_DEACTIVATED;
            default:
                next_state = saf_pkg::ST_RESET;
        endcase
        // Reset always overrides the table above; pulse test and deactivation commands override it outside their excluded states
        if (cmd_code == saf_pkg::CMD_RESET)
            next_state = saf_pkg::ST_RESET; // [R2]
        else if (cmd_code == saf_pkg::CMD_SINGLE_PULSE && !is_test)
            next_state = saf_pkg::ST_TEST_SINGLE; // [R3] [R4]
        else if (cmd_code == saf_pkg::CMD_CONT_PULSE && !is_test)
            next_state = saf_pkg::ST_TEST_CONT; // [R3] [R4]
        else if (cmd_code == saf_pkg::CMD_DEACT_REQ
            && state != saf_pkg::ST_PEND_DEACT
            && state != saf_pkg::ST_WAIT_CONFIRM
            && state != saf_pkg::ST_RESET
            && (nt_mode || state != saf_pkg::ST_DEACTIVATED))
            next_state = saf_pkg::ST_PEND_DEACT; // [R1]
        if (next_state != saf_pkg::ST_PEND_ACT
            && next_state != saf_pkg::ST_ACTIVATED
            && next_state != saf_pkg::ST_WAIT_SWITCH)
            next_loop = 1'b0;
    end

    // Transmit and indication decode from the next state
    saf_pkg::saf_tx_type next_tx;
    logic [3:0] next_ind;
    always_comb
    begin
        next_tx = saf_pkg::TX_INFO0; // [R1] [R2] [R15]
        next_ind = saf_pkg::IND_DEACT_DONE;
        case (next_state)
            saf_pkg::ST_RESET:
                next_ind = saf_pkg::IND_RESET_ACK;
            saf_pkg::ST_DEACTIVATED:
                next_ind = saf_pkg::IND_DEACT_DONE;
            saf_pkg::ST_INFO0_SEEN:
                next_ind = saf_pkg::IND_ACT_REQ; // [R11]
            saf_pkg::ST_PEND_ACT, saf_pkg::ST_WAIT_SWITCH:
            begin
                next_tx = saf_pkg::TX_INFO2; // [R17] [R18]
                next_ind = nt_mode ? saf_pkg::IND_ACT_REQ
                    : saf_pkg::IND_INTERIM; // [R9] [R11]
            end
            saf_pkg::ST_ACTIVATED:
            begin
                next_tx = saf_pkg::TX_INFO4; // [R19]
                next_ind = next_loop ? saf_pkg::IND_LOOP_ACT
                    : saf_pkg::IND_ACT_DONE; // [R13]
            end
            saf_pkg::ST_LOST_LINE, saf_pkg::ST_LOST_UP:
            begin
                next_tx = saf_pkg::TX_INFO2; // [R20] [R21]
                next_ind = saf_pkg::IND_RX_UNSYNCED;
            end
            saf_pkg::ST_PEND_DEACT:
                next_ind = saf_pkg::IND_INTERIM; // [R9]
            saf_pkg::ST_WAIT_CONFIRM:
                next_ind = saf_pkg::IND_DEACT_DONE; // [R14]
            saf_pkg::ST_TEST_SINGLE:
            begin
                next_tx = saf_pkg::TX_SINGLE; // [R3]
                next_ind = saf_pkg::IND_TEST_ACK;
            end
            saf_pkg::ST_TEST_CONT:
            begin
                next_tx = saf_pkg::TX_CONT; // [R3]
                next_ind = saf_pkg::IND_TEST_ACK;
            end
            default:
                next_ind = saf_pkg::IND_DEACT_DONE;
        endcase
        // Receiver and violation reports take precedence when line is live
        if (next_state != saf_pkg::ST_RESET
            && next_state != saf_pkg::ST_TEST_SINGLE
            && next_state != saf_pkg::ST_TEST_CONT
            && next_state != saf_pkg::ST_DEACTIVATED)
        begin
            if (rx.level && !rx.synced)
                next_ind = saf_pkg::IND_RX_UNSYNCED; // [R10]
            else if (rx.code_viol && code_violation_enable)
                next_ind = saf_pkg::IND_CODE_VIOL; // [R12]
        end
    end

    // State, timers and registered outputs
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= saf_pkg::ST_RESET;
            quiet_count <= saf_pkg::TIMER_ZERO;
            expiry_count <= saf_pkg::TIMER_ZERO;
            ind_code <= saf_pkg::IND_RESET_VALUE;
            tx_info <= saf_pkg::TX_INFO0;
            loop_closed <= 1'b0;
            channels_transparent <= 1'b0;
            clocks_stopped <= 1'b0;
        end
        else
        begin
            state <= next_state;
            // Timers restart on every entry into pending deactivation
            if (state != saf_pkg::ST_PEND_DEACT)
            begin
                quiet_count <= saf_pkg::TIMER_ZERO; // [R24]
                expiry_count <= saf_pkg::TIMER_ZERO; // [R24]
            end
            else
            begin
                expiry_count <= expiry_count + 20'h00001; // [R24]
                quiet_count <= rx.info0 ? quiet_count + 20'h00001
                    : saf_pkg::TIMER_ZERO; // [R14]
            end
            ind_code <= next_ind;
            tx_info <= next_tx;
            loop_closed <= next_loop;
            channels_transparent <=
                next_state == saf_pkg::ST_ACTIVATED; // [R19]
            clocks_stopped <= clock_stop_select
                && next_state == saf_pkg::ST_DEACTIVATED; // [R15]
        end
    end

    // Checks next to the logic
    a_reset_info0: assert property (@(posedge clk) disable iff (rst) // [R2]
        cmd_code == saf_pkg::CMD_RESET |=> tx_info == saf_pkg::TX_INFO0
        && state == saf_pkg::ST_RESET)
        else $error("reset command did not silence line");
    a_deact_start: assert property (@(posedge clk) disable iff (rst) // [R1]
        cmd_code == saf_pkg::CMD_DEACT_REQ
        && state == saf_pkg::ST_ACTIVATED
        |=> state == saf_pkg::ST_PEND_DEACT && tx_info == saf_pkg::TX_INFO0)
        else $error("deactivation request not taken");
    // Only reset and pulse test commands may pre-empt the timer outcome
    a_deact_timeout: assert property (@(posedge clk) disable iff (rst) // [R14]
        state == saf_pkg::ST_PEND_DEACT && deact_fire
        && cmd_code != saf_pkg::CMD_RESET && cmd_code[3:1] != 3'b001
        |=> state == saf_pkg::ST_WAIT_CONFIRM)
        else $error("deactivation timer expiry ignored");
    a_switch_info4: assert property (@(posedge clk) disable iff (rst) // [R19]
        state == saf_pkg::ST_ACTIVATED |-> tx_info == saf_pkg::TX_INFO4
        && channels_transparent)
        else $error("activated without INFO 4");
    a_wait_confirm: assert property (@(posedge clk) disable iff (rst) // [R22]
        $past(state) == saf_pkg::ST_WAIT_CONFIRM
        && state == saf_pkg::ST_DEACTIVATED
        |-> $past(cmd_code) == saf_pkg::CMD_DEACT_CONFIRM)
        else $error("left wait state without confirmation");
    a_lost_sync: assert property (@(posedge clk) disable iff (rst) // [R20]
        state == saf_pkg::ST_ACTIVATED && !rx.synced
        && cmd_code[3] |=> state == saf_pkg::ST_LOST_LINE)
        else $error("loss of sync not followed");
    a_silent_idle: assert property (@(posedge clk) disable iff (rst) // [R15]
        state == saf_pkg::ST_DEACTIVATED |-> tx_info == saf_pkg::TX_INFO0
        && (clocks_stopped == clock_stop_select
        || $changed(clock_stop_select)))
        else $error("deactivated state not silent");
    a_nt_waits: assert property (@(posedge clk) disable iff (rst) // [R16]
        state == saf_pkg::ST_INFO0_SEEN
        && cmd_code == saf_pkg::CMD_DEACT_CONFIRM
        |=> state == saf_pkg::ST_INFO0_SEEN)
        else $error("NT proceeded without activation command");
    a_loop_close: assert property (@(posedge clk) disable iff (rst) // [R7]
        state == saf_pkg::ST_ACTIVATED && rx.synced
        && cmd_code == saf_pkg::CMD_LOOP_ACT_IND |=> loop_closed)
        else $error("loop 2 not closed on command");
    a_upstream_lost: assert property (@(posedge clk) disable iff (rst) // [R21]
        nt_mode && state == saf_pkg::ST_ACTIVATED && rx.synced
        && cmd_code == saf_pkg::CMD_RX_UNSYNCED
        |=> state == saf_pkg::ST_LOST_UP && tx_info == saf_pkg::TX_INFO2)
        else $error("upstream sync loss not followed");
    // Timers must start from zero on each entry into pending deactivation
    a_timer_restart: assert property (@(posedge clk) disable iff (rst) // [R24]
        state != saf_pkg::ST_PEND_DEACT
        |=> expiry_count == saf_pkg::TIMER_ZERO
        && quiet_count == saf_pkg::TIMER_ZERO)
        else $error("deactivation timers not restarted");
    a_quiet_count: assert property (@(posedge clk) disable iff (rst) // [R14]
        state == saf_pkg::ST_PEND_DEACT && !rx.info0
        |=> quiet_count == saf_pkg::TIMER_ZERO)
        else $error("quiet timer ran without INFO 0");
    a_reset_ack: assert property (@(posedge clk) disable iff (rst) // [R2]
        state == saf_pkg::ST_RESET && cmd_code == saf_pkg::CMD_RESET
        |=> ind_code == saf_pkg::IND_RESET_ACK)
        else $error("reset not acknowledged");
    a_pend_info2: assert property (@(posedge clk) disable iff (rst) // [R17]
        state == saf_pkg::ST_PEND_ACT |-> tx_info == saf_pkg::TX_INFO2
        && !channels_transparent)
        else $error("pending activation not sending INFO 2");
endmodule // saf_fsm

// file: src/saf_pkg.sv
// Package of codes, states, timing and carriers for the activation machine
package saf_pkg;
    // Command codes from the upstream controller
    localparam logic [3:0] CMD_DEACT_REQ = 4'h0;
    localparam logic [3:0] CMD_RESET = 4'h1;
    localparam logic [3:0] CMD_SINGLE_PULSE = 4'h2;
    localparam logic [3:0] CMD_CONT_PULSE = 4'h3;
    localparam logic [3:0] CMD_RX_UNSYNCED = 4'h4;
    localparam logic [3:0] CMD_ACT_REQ = 4'h8;
    localparam logic [3:0] CMD_LOOP_ACT_REQ = 4'hA;
    localparam logic [3:0] CMD_SWITCH_THROUGH = 4'hC;
    localparam logic [3:0] CMD_LOOP_ACT_IND = 4'hE;
    localparam logic [3:0] CMD_DEACT_CONFIRM = 4'hF;
    // Indication codes towards the upstream controller
    localparam logic [3:0] IND_INTERIM = 4'h0;
    localparam logic [3:0] IND_RESET_ACK = 4'h1;
    localparam logic [3:0] IND_TEST_ACK = 4'h2;
    localparam logic [3:0] IND_RX_UNSYNCED = 4'h4;
    localparam logic [3:0] IND_ACT_REQ = 4'h8;
    localparam logic [3:0] IND_CODE_VIOL = 4'hB;
    localparam logic [3:0] IND_ACT_DONE = 4'hC;
    localparam logic [3:0] IND_LOOP_ACT = 4'hE;
    localparam logic [3:0] IND_DEACT_DONE = 4'hF;
    // Reset value of the indication output
    localparam logic [3:0] IND_RESET_VALUE = 4'hF;
    // Transmitted line signal codes
    typedef enum logic [2:0]
    {
        TX_INFO0 = 3'b000,
        TX_INFO2 = 3'b001,
        TX_INFO4 = 3'b010,
        TX_SINGLE = 3'b011,
        TX_CONT = 3'b100
    } saf_tx_type;
    // Machine states
    typedef enum logic [3:0]
    {
        ST_RESET = 4'b0000,
        ST_DEACTIVATED = 4'b0001,
        ST_INFO0_SEEN = 4'b0010,
        ST_PEND_ACT = 4'b0011,
        ST_WAIT_SWITCH = 4'b0100,
        ST_ACTIVATED = 4'b0101,
        ST_LOST_LINE = 4'b0110,
        ST_LOST_UP = 4'b0111,
        ST_PEND_DEACT = 4'b1000,
        ST_WAIT_CONFIRM = 4'b1001,
        ST_TEST_SINGLE = 4'b1010,
        ST_TEST_CONT = 4'b1011
    } saf_state_type;
    // Line receiver status, grouped
    typedef struct packed {
        logic info0;
        logic level;
        logic info3;
        logic synced;
        logic code_viol;
    } saf_rx_type;
    // Timing: clock rate and deactivation timers
    localparam int CLK_HZ = 10000000;
    localparam int QUIET_MS = 16;
    localparam int EXPIRY_MS = 32;
    localparam int QUIET_CYCLES = QUIET_MS * (CLK_HZ / 1000);
    localparam int EXPIRY_CYCLES = EXPIRY_MS * (CLK_HZ / 1000);
    localparam int TIMER_WIDTH = 20;
    localparam logic [19:0] TIMER_ZERO = 20'h00000;
endpackage

// file: testbench/saf_terminal_model.sv
// Behavioural terminal on the S/T line facing the activation machine
`timescale 1ns/1ns
module saf_terminal_model
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Line transmitter of the device
    input wire saf_pkg::saf_tx_type tx_info,
    // Scenario controls from the bench
    input wire logic want_act,
    input wire logic lose_sync,
    input wire logic inject_cv,
    input wire logic [3:0] answer_delay,
    // Receiver status seen by the device
    output saf_pkg::saf_rx_type rx_status
);
    logic [3:0] seen_info2;
    logic answered;

    // Count cycles of INFO 2 before the terminal answers with INFO 3
    always_ff @(posedge clk)
    begin
        if (rst || !want_act || tx_info == saf_pkg::TX_INFO0)
            seen_info2 <= 4'h0;
        else if (!answered)
            seen_info2 <= seen_info2 + 4'h1;
    end
    assign answered = want_act && seen_info2 >= answer_delay;

    // Idle terminal sends nothing; a waking one is seen as INFO 0 detected
    always_comb
    begin
        rx_status = '0;
        if (want_act && !answered)
            rx_status.info0 = 1'b1;
        if (answered)
        begin
            rx_status.level = 1'b1;
            rx_status.info3 = !lose_sync;
            rx_status.synced = !lose_sync;
            rx_status.code_viol = inject_cv;
        end
    end
endmodule // saf_terminal_model

// file: testbench/saf_fsm_bench.sv
// Self-checking bench for the layer-1 activation machine
`timescale 1ns/1ns
module saf_fsm_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic nt_mode = 1'b1;
    logic code_violation_enable = 1'b0;
    logic clock_stop_select = 1'b0;
    logic [3:0] cmd_code = 4'hF;
    logic [3:0] ind_code;
    saf_pkg::saf_rx_type rx_status;
    saf_pkg::saf_tx_type tx_info;
    logic channels_transparent;
    logic loop_closed;
    logic clocks_stopped;
    logic want_act = 1'b0;
    logic lose_sync = 1'b0;
    logic inject_cv = 1'b0;
    logic [3:0] answer_delay = 4'h2;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;
    logic css;

    saf_fsm saf_fsm_i (.clk(clk), .rst(rst), .nt_mode(nt_mode),
        .code_violation_enable(code_violation_enable),
        .clock_stop_select(clock_stop_select), .cmd_code(cmd_code),
        .ind_code(ind_code), .rx_status(rx_status), .tx_info(tx_info),
        .channels_transparent(channels_transparent),
        .loop_closed(loop_closed), .clocks_stopped(clocks_stopped));

    saf_terminal_model saf_terminal_model_i (.clk(clk), .rst(rst),
        .tx_info(tx_info), .want_act(want_act), .lose_sync(lose_sync),
        .inject_cv(inject_cv), .answer_delay(answer_delay),
        .rx_status(rx_status));

    // 10 MHz clock
    always #50 clk = ~clk;

    // Hang guard
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic test_done();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // Advance n cycles, leaving inputs free to change just after the edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask

    // Controller holds each command until the machine reacts
    task automatic cmd(input logic [3:0] code);
        step($urandom_range(1, 4));
        cmd_code = code;
    endtask

    // Bounded wait for an indication (bit 4 set: any) and a line signal
    task automatic wait_for(input logic [4:0] ie,
        input saf_pkg::saf_tx_type te);
        int k;
        for (k = 0; k < 20; k++)
        begin
            if ((ie[4] || ind_code === ie[3:0]) && tx_info === te)
                break;
            step(1);
        end
        if (!ie[4])
            check({4'h0, ind_code}, {4'h0, ie[3:0]});
        check({5'h00, tx_info}, {5'h00, te});
    endtask

    initial
    begin
        void'($urandom(32'h516D09A5));
        step(1);
        check({4'h0, ind_code}, {4'h0, saf_pkg::IND_RESET_VALUE});
        step(11);
        rst = 1'b0;
        cmd_code = saf_pkg::CMD_RESET;
        step(1);
        wait_for({1'b0, saf_pkg::IND_RESET_ACK}, saf_pkg::TX_INFO0);
        cmd(saf_pkg::CMD_DEACT_CONFIRM);
        wait_for({1'b0, saf_pkg::IND_DEACT_DONE}, saf_pkg::TX_INFO0);
        // NT activation started by the terminal
        answer_delay = 4'($urandom_range(1, 9));
        want_act = 1'b1;
        wait_for({1'b0, saf_pkg::IND_ACT_REQ}, saf_pkg::TX_INFO0);
        step(8);
        wait_for({1'b0, saf_pkg::IND_ACT_REQ}, saf_pkg::TX_INFO0);
        cmd(saf_pkg::CMD_ACT_REQ);
        wait_for(5'h10, saf_pkg::TX_INFO2);
        step(16);
        wait_for(5'h10, saf_pkg::TX_INFO2);
        check({7'h00, channels_transparent}, 8'h00);
        cmd(saf_pkg::CMD_SWITCH_THROUGH);
        wait_for({1'b0, saf_pkg::IND_ACT_DONE}, saf_pkg::TX_INFO4);
        check({7'h00, channels_transparent}, 8'h01);
        cmd(saf_pkg::CMD_LOOP_ACT_IND);
        wait_for({1'b0, saf_pkg::IND_LOOP_ACT}, saf_pkg::TX_INFO4);
        check({7'h00, loop_closed}, 8'h01);
        cmd(saf_pkg::CMD_SWITCH_THROUGH);
        // Violation shown only while enabled
        inject_cv = 1'b1;
        step(6);
        check({4'h0, ind_code}, {4'h0, saf_pkg::IND_LOOP_ACT});
        code_violation_enable = 1'b1;
        wait_for({1'b0, saf_pkg::IND_CODE_VIOL}, saf_pkg::TX_INFO4);
        inject_cv = 1'b0;
        code_violation_enable = 1'b0;
        // Line loses and regains sync
        lose_sync = 1'b1;
        wait_for({1'b0, saf_pkg::IND_RX_UNSYNCED}, saf_pkg::TX_INFO2);
        check({7'h00, channels_transparent}, 8'h00);
        lose_sync = 1'b0;
        wait_for({1'b0, saf_pkg::IND_ACT_DONE}, saf_pkg::TX_INFO4);
        cmd(saf_pkg::CMD_RX_UNSYNCED);
        wait_for(5'h10, saf_pkg::TX_INFO2);
        cmd(saf_pkg::CMD_SWITCH_THROUGH);
        wait_for({1'b0, saf_pkg::IND_ACT_DONE}, saf_pkg::TX_INFO4);
        // Deactivation: no indication of completion before the timers
        cmd(saf_pkg::CMD_DEACT_REQ);
        want_act = 1'b0;
        wait_for({1'b0, saf_pkg::IND_INTERIM}, saf_pkg::TX_INFO0);
        step(500);
        check({4'h0, ind_code}, {4'h0, saf_pkg::IND_INTERIM});
        check({7'h00, channels_transparent}, 8'h00);
        // Reset ignores the line while held
        want_act = 1'b1;
        cmd(saf_pkg::CMD_RESET);
        wait_for({1'b0, saf_pkg::IND_RESET_ACK}, saf_pkg::TX_INFO0);
        step(10);
        check({4'h0, ind_code}, {4'h0, saf_pkg::IND_RESET_ACK});
        want_act = 1'b0;
        // Pulse tests, never swapped directly
        cmd(saf_pkg::CMD_SINGLE_PULSE);
        wait_for(5'h10, saf_pkg::TX_SINGLE);
        cmd(saf_pkg::CMD_DEACT_CONFIRM);
        wait_for({1'b0, saf_pkg::IND_DEACT_DONE}, saf_pkg::TX_INFO0);
        cmd(saf_pkg::CMD_CONT_PULSE);
        wait_for(5'h10, saf_pkg::TX_CONT);
        cmd(saf_pkg::CMD_DEACT_CONFIRM);
        wait_for({1'b0, saf_pkg::IND_DEACT_DONE}, saf_pkg::TX_INFO0);
        // Clock stop follows its select bit while deactivated
        repeat (4)
        begin
            css = 1'($urandom);
            clock_stop_select = css;
            step(3);
            check({7'h00, clocks_stopped}, {7'h00, css});
        end
        clock_stop_select = 1'b0;
        cmd(saf_pkg::CMD_LOOP_ACT_REQ);
        step(4);
        check({7'h00, loop_closed}, 8'h01);
        // Exchange-side role: activation command starts INFO 2
        cmd(saf_pkg::CMD_RESET);
        wait_for({1'b0, saf_pkg::IND_RESET_ACK}, saf_pkg::TX_INFO0);
        cmd(saf_pkg::CMD_DEACT_CONFIRM);
        nt_mode = 1'b0;
        wait_for({1'b0, saf_pkg::IND_DEACT_DONE}, saf_pkg::TX_INFO0);
        cmd(saf_pkg::CMD_ACT_REQ);
        wait_for({1'b0, saf_pkg::IND_INTERIM}, saf_pkg::TX_INFO2);
        check({4'h0, ind_code}, {4'h0, saf_pkg::IND_INTERIM});
        test_done();
    end
endmodule // saf_fsm_bench
